/* bench/fsq_flash_model.sv */
// behavioural flash array answering erase and row program requests
module fsq_flash_model (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_erase,
  input  wire logic       i_row,
  input  wire logic [7:0] i_delay,
  output logic            o_done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt_r;
  // ==========================================================
  // busy time; done pulses once, so a slow bench cannot double count
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r  <= 8'h00;
      o_done <= 1'b0;
    end else begin
      cnt_r  <= (i_erase | i_row) ? cnt_r + 8'h01 : 8'h00;
      o_done <= (i_erase | i_row) && (cnt_r == i_delay);
    end
  end
endmodule : fsq_flash_model

/* bench/fsq_flash_seq_tb_top.sv */
// self-checking bench for the flash self-program sequencer
`include "fsq_regs.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
  err_total++; $display("wrong value at %0t: got %h want %h", \
  $time, (g), (e)); end end
module fsq_flash_seq_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import fsq_pkg::*;
  logic        clk   = 1'b0;
  logic        rst_n = 1'b0;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic [7:0]  adr   = 8'h00;
  logic [3:0]  sel   = 4'h0;
  logic [31:0] wdat  = 32'h0000_0000;
  logic [7:0]  dly   = 8'h02;
  logic [31:0] rdat;
  logic        ack, done, erase, row, stall, irq;
  fsq_addr_t   faddr;
  logic [15:0] page;
  int          err_total    = 0;
  int          total_checks = 0;
  // ==========================================================
  // clock, design and array model
  always #25 clk = ~clk;
  fsq_flash_seq DUT (
    .I_SYS_CLK   (clk),
    .I_RST_N     (rst_n),
    .I_WB_CYC    (cyc),
    .I_WB_STB    (stb),
    .I_WB_WE     (we),
    .I_WB_ADR    (adr),
    .I_WB_SEL    (sel),
    .I_WB_DAT    (wdat),
    .O_WB_DAT    (rdat),
    .O_WB_ACK    (ack),
    .I_FL_DONE   (done),
    .O_FL_ERASE  (erase),
    .O_FL_ROW    (row),
    .O_FL_ADDR   (faddr),
    .O_FL_PAGE   (page),
    .O_CPU_STALL (stall),
    .O_IRQ       (irq)
  );
  fsq_flash_model u_arr (
    .i_clk   (clk),
    .i_rst_n (rst_n),
    .i_erase (erase),
    .i_row   (row),
    .i_delay (dly),
    .o_done  (done)
  );
  // ==========================================================
  // common tasks
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test
  // one classic cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [15:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= 4'hf;
    wdat <= {16'h0000, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      err_total++;
      end_of_test();
    end
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr
  task automatic chk_rd(input logic [7:0] a, input logic [15:0] e);
    logic [31:0] q;
    wb(1'b0, a, 16'h0000, q);
    `CHK(q, {16'h0000, e})
  endtask : chk_rd
  // key pair then control write; outputs looked at once settled
  task automatic launch(input logic [15:0] c);
    wr(`FSQ_OFF_KEY, `FSQ_KEY_FIRST);
    wr(`FSQ_OFF_KEY, `FSQ_KEY_SECOND);
    wr(`FSQ_OFF_CTRL, c);
    // one quiet bus slot and half of the next after the start write, like code running no-ops
    @(posedge clk);
    @(negedge clk);
  endtask : launch
  task automatic wait_idle();
    int n;
    n = 0;
    while (stall !== 1'b0 && n < 400) begin
      @(posedge clk);
      n++;
    end
    if (stall !== 1'b0) begin
      err_total++;
      end_of_test();
    end
  endtask : wait_idle
  // ==========================================================
  // scenarios
  task automatic t_erase();
    dly <= 8'd40;
    chk_rd(`FSQ_OFF_CTRL, `FSQ_RST_CTRL);
    chk_rd(8'h20, 16'h0000);
    wr(`FSQ_OFF_IRQ_EN, 16'h0001);
    wr(`FSQ_OFF_ADDR_LO, 16'h2345);
    wr(`FSQ_OFF_ADDR_HI, 16'h0001);
    launch(16'hc003);
    `CHK({erase, row, stall}, 3'b101)
    `CHK(faddr, 24'h012345 & `FSQ_BLK_MASK)
    wr(`FSQ_OFF_CTRL, 16'h0000); // busy write must be dropped
    chk_rd(`FSQ_OFF_CTRL, 16'hc003);
    wait_idle();
    chk_rd(`FSQ_OFF_CTRL, 16'h4003);
    chk_rd(`FSQ_OFF_STATUS, 16'h0001);
    `CHK(irq, 1'b1)
  endtask : t_erase
  task automatic t_row();
    dly <= 8'd2;
    wr(`FSQ_OFF_IRQ_CLR, 16'h0001);
    wr(`FSQ_OFF_IRQ_EN, 16'h0000);
    chk_rd(`FSQ_OFF_PAGE, `FSQ_RST_PAGE);
    `CHK(irq, 1'b0)
    wr(`FSQ_OFF_PAGE, 16'h00fa);
    wr(`FSQ_OFF_ADDR_LO, 16'h0400);
    launch(16'hc002);
    `CHK({erase, row, stall}, 3'b011)
    `CHK({page, faddr}, {16'h00fa, 24'h010400})
    wait_idle();
    chk_rd(`FSQ_OFF_CTRL, 16'h4002);
    chk_rd(`FSQ_OFF_STATUS, 16'h0001);
    `CHK(irq, 1'b0)
    // next row of the same block: address moves up by one row
    wr(`FSQ_OFF_ADDR_LO, 16'h0800);
    launch(16'hc002);
    `CHK({row, faddr}, {1'b1, 24'h010800})
    wait_idle();
    chk_rd(`FSQ_OFF_CTRL, 16'h4002);
  endtask : t_row
  task automatic t_refuse();
    wr(`FSQ_OFF_IRQ_CLR, 16'h0003);
    wr(`FSQ_OFF_IRQ_EN, 16'h0002);
    wr(`FSQ_OFF_CTRL, 16'hc003);
    @(negedge clk);
    `CHK({erase, stall}, 2'b00)
    chk_rd(`FSQ_OFF_CTRL, 16'h6003);
    wr(`FSQ_OFF_KEY, `FSQ_KEY_FIRST);
    wr(`FSQ_OFF_KEY, `FSQ_KEY_SECOND);
    wr(`FSQ_OFF_PAGE, 16'h0001);
    wr(`FSQ_OFF_CTRL, 16'hc003);
    @(negedge clk);
    `CHK({erase, stall}, 2'b00)
    launch(16'h8003);
    `CHK({erase, stall}, 2'b00)
    launch(16'hc001);
    `CHK({erase, row, stall}, 3'b000)
    chk_rd(`FSQ_OFF_STATUS, 16'h0002);
    `CHK(irq, 1'b1)
  endtask : t_refuse
  // ==========================================================
  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_erase();
    t_row();
    t_refuse();
    end_of_test();
  end
endmodule : fsq_flash_seq_tb_top

/* design/fsq_flash_seq.sv */
// flash self-program sequencer with wishbone register slave
// What this block does
// - erase works only on whole eight-row blocks, address aligned to block.
// - one row program moves 128 latch words into the array.
// - operation select 0011 starts a block erase.
// - operation select 0010 starts a single row program.
// - no operation proceeds without the unlock key sequence.
// - start bit 15 begins the operation; processor stalls throughout.
// - hardware clears the start bit when the operation completes.
`include "fsq_regs.svh"
module fsq_flash_seq
  import fsq_pkg::*;
(
  input  wire logic        I_SYS_CLK,
  input  wire logic        I_RST_N,
  input  wire logic        I_WB_CYC,
  input  wire logic        I_WB_STB,
  input  wire logic        I_WB_WE,
  input  wire logic [7:0]  I_WB_ADR,
  input  wire logic [3:0]  I_WB_SEL,
  input  wire logic [31:0] I_WB_DAT,
  output logic      [31:0] O_WB_DAT,
  output logic             O_WB_ACK,
  input  wire logic        I_FL_DONE,
  output logic             O_FL_ERASE,
  output logic             O_FL_ROW,
  output fsq_pkg::fsq_addr_t O_FL_ADDR,
  output logic      [15:0] O_FL_PAGE,
  output logic             O_CPU_STALL,
  output logic             O_IRQ
);
  import fsq_pkg::*;

  // ==========================================================
  // bus decode
  logic [15:0] ctrl_r, addr_lo_r, addr_hi_r, page_r;
  logic [1:0]  sts_r, ien_r;
  logic        ack_r, irq_r, stall_r, erase_r, row_r;
  logic [31:0] rdat_r;
  fsq_addr_t   fl_addr_r;
  fsq_state_e  st_r;
  fsq_key_e    key_r;

  wire         req      = I_WB_CYC & I_WB_STB & ~ack_r;
  wire         wr       = req & I_WB_WE & I_WB_SEL[0] & I_WB_SEL[1];
  wire         sel_ctrl = I_WB_ADR == `FSQ_OFF_CTRL;
  wire         sel_key  = I_WB_ADR == `FSQ_OFF_KEY;
  wire         sel_alo  = I_WB_ADR == `FSQ_OFF_ADDR_LO;
  wire         sel_ahi  = I_WB_ADR == `FSQ_OFF_ADDR_HI;
  wire         sel_page = I_WB_ADR == `FSQ_OFF_PAGE;
  wire         sel_sts  = I_WB_ADR == `FSQ_OFF_STATUS;
  wire         sel_clr  = I_WB_ADR == `FSQ_OFF_IRQ_CLR;
  wire         sel_ien  = I_WB_ADR == `FSQ_OFF_IRQ_EN;
  wire [15:0]  wdat     = I_WB_DAT[15:0];
  wire         busy     = st_r != FSQ_IDLE;
  wire [3:0]   opsel    = ctrl_r[`FSQ_OP_HI:`FSQ_OP_LO];
  // operation field of the word being written
  wire [3:0]   wop      = wdat[`FSQ_OP_HI:`FSQ_OP_LO];

  // ==========================================================
  // start decision: key armed, write enable set, valid op
  wire         wr_ctrl  = wr & sel_ctrl & ~busy;
  wire         start_req = wr_ctrl & wdat[`FSQ_CTRL_START];
  // only the erase and row codes may start anything
  wire         op_ok    = wop == `FSQ_OP_ERASE ||
                          wop == `FSQ_OP_ROW;
  wire         go       = start_req & (key_r == FSQ_K_ARMED) &
                          wdat[`FSQ_CTRL_WRITE_EN] & op_ok;
  wire         refuse   = start_req & ~go;
  wire         op_done  = st_r == FSQ_WAIT;
  wire fsq_addr_t tgt   = {addr_hi_r[7:0], addr_lo_r};
  wire         do_erase = wop == `FSQ_OP_ERASE;
  // word stored on a control write; a refused start reads back low
  // and leaves the refused flag set so software can tell why
  wire [15:0]  ctrl_nxt = {go, wdat[`FSQ_CTRL_WRITE_EN], refuse, 9'h000,
                           wop};

  // ==========================================================
  // unlock key tracker: any other write in between disarms
  // reads leave it alone, so a status poll between keys is harmless
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      key_r <= FSQ_K_NONE;
    end else if (wr) begin
      if (sel_key && wdat == `FSQ_KEY_FIRST) begin
        key_r <= FSQ_K_ONE;
      end else if (sel_key && wdat == `FSQ_KEY_SECOND &&
                   key_r == FSQ_K_ONE) begin
        key_r <= FSQ_K_ARMED;
      end else begin
        key_r <= FSQ_K_NONE;
      end
    end
  end

  // ==========================================================
  // control register; start stays high until completion
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ctrl_r <= `FSQ_RST_CTRL;
    end else if (op_done) begin
      ctrl_r[`FSQ_CTRL_START] <= 1'b0;
    end else if (wr_ctrl) begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // address pair and page pointer, locked while busy
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      addr_lo_r <= 16'h0000;
      addr_hi_r <= 16'h0000;
      page_r    <= `FSQ_RST_PAGE;
    end else if (wr && !busy) begin
      if (sel_alo) addr_lo_r <= wdat;
      if (sel_ahi) addr_hi_r <= {8'h00, wdat[7:0]};
      if (sel_page) page_r <= wdat;
    end
  end

  // ==========================================================
  // sequencer: array strobes held until the array reports done
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      st_r      <= FSQ_IDLE;
      erase_r   <= 1'b0;
      row_r     <= 1'b0;
      stall_r   <= 1'b0;
      fl_addr_r <= 24'h000000;
    end else begin
      case (st_r)
        FSQ_IDLE: begin
          if (go) begin
            st_r    <= do_erase ? FSQ_ERASE : FSQ_PROG;
            erase_r <= do_erase;
            row_r   <= ~do_erase;
            stall_r <= 1'b1;
            // erase aligns to the 8-row block, program to one row
            fl_addr_r <= do_erase ? (tgt & `FSQ_BLK_MASK)
                                  : (tgt & `FSQ_ROW_MASK);
          end
        end
        FSQ_ERASE, FSQ_PROG: begin
          // no timer here: the array alone says when it is finished
          if (I_FL_DONE) begin
            erase_r <= 1'b0;
            row_r   <= 1'b0;
            st_r    <= FSQ_WAIT;
          end
        end
        FSQ_WAIT: begin
          stall_r <= 1'b0;
          st_r    <= FSQ_IDLE;
        end
        default: st_r <= FSQ_IDLE;
      endcase
    end
  end

  // ==========================================================
  // sticky status: set wins over clear
  wire [1:0] sts_set = {refuse, op_done};
  wire [1:0] sts_clr = (wr && sel_clr) ? wdat[1:0] : 2'b00;
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      sts_r <= 2'b00;
      ien_r <= 2'b00;
      irq_r <= 1'b0;
    end else begin
      sts_r <= (sts_r & ~sts_clr) | sts_set;
      if (wr && sel_ien) ien_r <= wdat[1:0];
      irq_r <= |(((sts_r & ~sts_clr) | sts_set) & ien_r);
    end
  end

  // ==========================================================
  // read mux and ack; answer one cycle after request
  // ack masks the request, so a held cycle is taken only once
  wire [15:0] rmux =
      sel_ctrl ? ctrl_r :
      sel_alo  ? addr_lo_r :
      sel_ahi  ? addr_hi_r :
      sel_page ? page_r :
      sel_sts  ? {14'h0000, sts_r} :
      sel_ien  ? {14'h0000, ien_r} : 16'h0000;
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ack_r  <= 1'b0;
      rdat_r <= 32'h00000000;
    end else begin
      ack_r  <= req;
      rdat_r <= {16'h0000, rmux};
    end
  end

  assign O_WB_ACK    = ack_r;
  assign O_WB_DAT    = rdat_r;
  assign O_FL_ERASE  = erase_r;
  assign O_FL_ROW    = row_r;
  assign O_FL_ADDR   = fl_addr_r;
  assign O_FL_PAGE   = page_r;
  assign O_CPU_STALL = stall_r;
  assign O_IRQ       = irq_r;

  // ==========================================================
  // checks on the start path
  lock_key_a: assert property (@(posedge I_SYS_CLK)
    disable iff (!I_RST_N)
    $rose(stall_r) |-> $past(key_r) == FSQ_K_ARMED)
    else $error("operation started without unlock key");

  key_disarm_a: assert property (@(posedge I_SYS_CLK)
    disable iff (!I_RST_N)
    (wr && !sel_key) |=> key_r == FSQ_K_NONE)
    else $error("key stays armed after other write");

  key_order_a: assert property (@(posedge I_SYS_CLK)
    disable iff (!I_RST_N)
    key_r == FSQ_K_ARMED |-> $past(key_r) != FSQ_K_NONE)
    else $error("key armed without first key");

  go_start_a: assert property (@(posedge I_SYS_CLK)
    disable iff (!I_RST_N)
    go |=> stall_r && ctrl_r[`FSQ_CTRL_START] && (erase_r || row_r))
    else $error("accepted start did not begin operation");

  refuse_flag_a: assert property (@(posedge I_SYS_CLK)
    disable iff (!I_RST_N)
    refuse |=> sts_r[`FSQ_ST_REFUSED] && !stall_r &&
               !ctrl_r[`FSQ_CTRL_START])
    else $error("refused start still took effect");

  // ==========================================================
  // checks on the running operation
  start_clr_a: assert property (@(posedge I_SYS_CLK)
    disable iff (!I_RST_N)
    op_done |=> !ctrl_r[`FSQ_CTRL_START])
    else $error("start bit not cleared at completion");

  start_hold_a: assert property (@(posedge I_SYS_CLK)
    disable iff (!I_RST_N)
    (erase_r || row_r) |-> ctrl_r[`FSQ_CTRL_START])
    else $error("start bit low during operation");

  stall_op_a: assert property (@(posedge I_SYS_CLK)
    disable iff (!I_RST_N)
    (erase_r || row_r) |-> stall_r)
    else $error("processor not stalled during operation");

  busy_stall_a: assert property (@(posedge I_SYS_CLK)
    disable iff (!I_RST_N)
    busy |-> stall_r)
    else $error("sequencer busy without stall");

  done_flag_a: assert property (@(posedge I_SYS_CLK)
    disable iff (!I_RST_N)
    op_done |=> sts_r[`FSQ_ST_DONE] && !stall_r)
    else $error("completion not flagged or stall kept");

  erase_sel_a: assert property (@(posedge I_SYS_CLK)
    disable iff (!I_RST_N)
    $rose(erase_r) |-> opsel == `FSQ_OP_ERASE)
    else $error("erase without erase select");

  row_sel_a: assert property (@(posedge I_SYS_CLK)
    disable iff (!I_RST_N)
    $rose(row_r) |-> opsel == `FSQ_OP_ROW)
    else $error("row program without row select");

  blk_align_a: assert property (@(posedge I_SYS_CLK)
    disable iff (!I_RST_N)
    erase_r |-> (fl_addr_r & ~`FSQ_BLK_MASK) == 24'h000000)
    else $error("erase address not block aligned");

  row_align_a: assert property (@(posedge I_SYS_CLK)
    disable iff (!I_RST_N)
    row_r |-> (fl_addr_r & ~`FSQ_ROW_MASK) == 24'h000000)
    else $error("row address not row aligned");

  // ==========================================================
  // checks on the bus and the interrupt
  ack_pulse_a: assert property (@(posedge I_SYS_CLK)
    disable iff (!I_RST_N)
    ack_r |=> !ack_r)
    else $error("ack longer than one cycle");

  irq_level_a: assert property (@(posedge I_SYS_CLK)
    disable iff (!I_RST_N)
    $stable(ien_r) |-> irq_r == |(sts_r & ien_r))
    else $error("interrupt does not follow enabled status");

  // main scenarios
  erase_c: cover property (@(posedge I_SYS_CLK) $rose(erase_r));
  row_c: cover property (@(posedge I_SYS_CLK) $rose(row_r));
  refuse_c: cover property (@(posedge I_SYS_CLK) refuse);
  armed_c: cover property (@(posedge I_SYS_CLK) key_r == FSQ_K_ARMED);
  done_c: cover property (@(posedge I_SYS_CLK) op_done);
endmodule : fsq_flash_seq

/* design/fsq_pkg.sv */
// types shared by the flash self-program sequencer
package fsq_pkg;
  typedef enum logic [1:0] {
    FSQ_IDLE, FSQ_ERASE, FSQ_PROG, FSQ_WAIT
  } fsq_state_e;
  typedef enum logic [1:0] {
    FSQ_K_NONE, FSQ_K_ONE, FSQ_K_ARMED
  } fsq_key_e;
  typedef logic [23:0] fsq_addr_t;
endpackage : fsq_pkg

/* design/fsq_regs.svh */
// register offsets, field positions, reset values and timing counts
`ifndef FSQ_REGS_SVH
`define FSQ_REGS_SVH
// ==========================================================
// register byte offsets
`define FSQ_OFF_CTRL      8'h00
`define FSQ_OFF_KEY       8'h04
`define FSQ_OFF_ADDR_LO   8'h08
`define FSQ_OFF_ADDR_HI   8'h0c
`define FSQ_OFF_PAGE      8'h10
`define FSQ_OFF_STATUS    8'h14
`define FSQ_OFF_IRQ_CLR   8'h18
`define FSQ_OFF_IRQ_EN    8'h1c
// ==========================================================
// control fields
`define FSQ_CTRL_START    15
`define FSQ_CTRL_WRITE_EN 14
`define FSQ_CTRL_ERR      13
`define FSQ_OP_HI         3
`define FSQ_OP_LO         0
`define FSQ_OP_ERASE      4'h3
`define FSQ_OP_ROW        4'h2
`define FSQ_KEY_FIRST     16'h0055
`define FSQ_KEY_SECOND    16'h00aa
// ==========================================================
// status / interrupt bits
`define FSQ_ST_DONE       0
`define FSQ_ST_REFUSED    1
`define FSQ_RST_CTRL      16'h0000
`define FSQ_RST_PAGE      16'h0000
// ==========================================================
// geometry and timing
`define FSQ_ROWS_PER_BLK  8
`define FSQ_WORDS_PER_ROW 128
`define FSQ_ROW_MASK      24'hfffc00
`define FSQ_BLK_MASK      24'hffe000
`define FSQ_ERASE_CYC     16'h0040
`define FSQ_ARRAY_DONE_TO 16'h0000
`endif
